// file: design/pdt_timer.sv
// ten-bit periodic timer with AHB-Lite register slave
// assumes: pins synchronous to hclk, one slave on the bus, zero wait
`timescale 1ns/1ps
`include "pdt_timer_consts.svh"
module pdt_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_clock_pin,
  input wire logic capture_input_pin,
  output logic timer_out,
  output logic timer_out_en
);
  import pdt_timer_pkg::*;

  logic [`PDT_CTRL_W-1:0] ctrl_q;
  logic [1:0] cclr_q;
  logic edge_flag_q;
  logic flag_a_q, flag_p_q;
  pdt_timer_pkg::pdt_word_t cnt_q, compare_register_a_q, compare_register_b_q, period_register_q;
  logic [`PDT_DIV_W-1:0] div_q;
  logic tick_q;
  logic run_prev_q, ckp_prev_q, cap_prev_q;
  logic lvl_q, pend_q, pend_rise_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic [31:0] rdata_q;
  logic out_q, out_en_q;

  pdt_mode_t mode;
  logic [1:0] pinfn;
  logic run, init_lvl, inv, clr_src;
  assign mode = pdt_mode_t'(ctrl_q[`PDT_F_MODE]);
  assign pinfn = ctrl_q[`PDT_F_PINFN];
  assign run = ctrl_q[`PDT_B_RUN];
  assign init_lvl = ctrl_q[`PDT_B_INIT];
  assign inv = ctrl_q[`PDT_B_INV];
  assign clr_src = ctrl_q[`PDT_B_CLRSRC];

  // bus: zero-wait, read data registered from the address phase
  logic addr_ok, bus_wr;
  assign addr_ok = hsel && hready && htrans[1];
  assign bus_wr = wr_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= addr_ok && hwrite;
      wa_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `PDT_OFF_CTRL: rdata_q <= {23'h000000, ctrl_q};
        `PDT_OFF_CTRL2: rdata_q <= {29'h00000000, cclr_q, edge_flag_q};
        `PDT_OFF_FLAGS: rdata_q <= {30'h00000000, flag_p_q, flag_a_q};
        `PDT_OFF_COUNT: rdata_q <= {22'h000000, cnt_q};
        `PDT_OFF_COMPARE_REGISTER_A: rdata_q <= {22'h000000, compare_register_a_q};
        `PDT_OFF_COMPARE_REGISTER_B: rdata_q <= {22'h000000, compare_register_b_q};
        `PDT_OFF_PERIOD_REGISTER: rdata_q <= {22'h000000, period_register_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rdata_q;

  // timer clock: one-cycle enable from a fixed divider of hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else if (div_q == `PDT_DIV_W'(`PDT_TICK_DIV - 1)) begin
      div_q <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + `PDT_DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // comparators and edges
  logic run_rise, ckp_rise, a_hit, p_hit, is_cmp, is_sp, is_pwm, is_cap;
  logic step, duty_full, duty_on;
  logic src, src_rise, src_fall, cap_evt, clr_evt, latch;
  pdt_word_t period_register_m1;
  logic [10:0] period;
  assign run_rise = run && !run_prev_q;
  assign ckp_rise = timer_clock_pin && !ckp_prev_q;
  assign is_cmp = (mode == PDT_MODE_CMP) || (mode == PDT_MODE_TC);
  assign is_pwm = (mode == PDT_MODE_PWM) && (pinfn != `PDT_PIN_ONCE);
  assign is_sp = (mode == PDT_MODE_PWM) && (pinfn == `PDT_PIN_ONCE);
  assign is_cap = (mode == PDT_MODE_CAP);
  assign step = tick_q && run;
  // period 0 wraps to 3FF, so clearing after it gives 1024 counts
  assign period_register_m1 = period_register_q - `PDT_WORD_ONE;
  assign p_hit = (cnt_q == period_register_m1);
  // a zero compare A never matches in compare mode
  assign a_hit = (cnt_q == compare_register_a_q) && !(is_cmp && compare_register_a_q == `PDT_WORD_RST);
  assign period = {period_register_q == `PDT_WORD_RST, period_register_q};
  assign duty_full = ({1'b0, compare_register_a_q} >= period);
  assign duty_on = duty_full || (cnt_q < compare_register_a_q);
  assign src = ctrl_q[`PDT_B_CAPSRC] ? timer_clock_pin : capture_input_pin;
  assign src_rise = src && !cap_prev_q;
  assign src_fall = !src && cap_prev_q;
  always_comb begin
    cap_evt = 1'b0;
    case (pinfn)
      `PDT_EDGE_RISE: cap_evt = src_rise;
      `PDT_EDGE_FALL: cap_evt = src_fall;
      `PDT_EDGE_BOTH: cap_evt = src_rise || src_fall;
      default: cap_evt = 1'b0;
    endcase
    clr_evt = 1'b0;
    case (cclr_q)
      `PDT_CLR_RISE: clr_evt = src_rise;
      `PDT_CLR_FALL: clr_evt = src_fall;
      `PDT_CLR_BOTH: clr_evt = src_rise || src_fall;
      default: clr_evt = 1'b0;
    endcase
  end
  assign latch = is_cap && run && cap_evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_prev_q <= 1'b0;
      ckp_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run;
      ckp_prev_q <= timer_clock_pin;
      cap_prev_q <= src;
    end
  end

  // control: hardware set or clear of run wins over the software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PDT_CTRL_RST;
    end else begin
      if (bus_wr && wa_q == `PDT_OFF_CTRL) begin
        ctrl_q <= hwdata[`PDT_CTRL_W-1:0];
      end
      if (is_sp && step && a_hit) begin
        ctrl_q[`PDT_B_RUN] <= 1'b0;
      end else if (is_sp && ckp_rise) begin
        ctrl_q[`PDT_B_RUN] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cclr_q <= 2'h0;
    end else if (bus_wr && wa_q == `PDT_OFF_CTRL2) begin
      cclr_q <= hwdata[`PDT_F_CCLR];
    end
  end

  // counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= `PDT_WORD_RST;
    end else if (is_sp && run_rise) begin
      cnt_q <= `PDT_WORD_RST;
    end else if (is_cap && run && clr_evt) begin
      cnt_q <= `PDT_WORD_RST;
    end else if (step) begin
      if (is_cmp && (clr_src ? a_hit : p_hit)) begin
        cnt_q <= `PDT_WORD_RST;
      end else if ((is_pwm || is_cap) && p_hit) begin
        cnt_q <= `PDT_WORD_RST;
      end else begin
        cnt_q <= cnt_q + `PDT_WORD_ONE;
      end
    end
  end

  // compare registers; a capture beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_register_a_q <= `PDT_WORD_RST;
      compare_register_b_q <= `PDT_WORD_RST;
      period_register_q <= `PDT_WORD_RST;
    end else begin
      if (bus_wr && wa_q == `PDT_OFF_COMPARE_REGISTER_A) compare_register_a_q <= hwdata[`PDT_F_WORD];
      if (bus_wr && wa_q == `PDT_OFF_COMPARE_REGISTER_B) compare_register_b_q <= hwdata[`PDT_F_WORD];
      if (bus_wr && wa_q == `PDT_OFF_PERIOD_REGISTER) period_register_q <= hwdata[`PDT_F_WORD];
      if (latch && clr_evt) begin
        compare_register_b_q <= cnt_q;
      end else if (latch) begin
        compare_register_a_q <= cnt_q;
      end
    end
  end

  // latch flags trail the capture by up to one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      pend_rise_q <= 1'b0;
      edge_flag_q <= 1'b0;
    end else begin
      if (latch) begin
        pend_q <= 1'b1;
        pend_rise_q <= src_rise;
      end else if (tick_q) begin
        pend_q <= 1'b0;
      end
      if (pend_q && tick_q) begin
        edge_flag_q <= pend_rise_q;
      end
    end
  end

  // status flags: write 1 to clear, a set in the same cycle wins
  logic set_a, set_p;
  assign set_a = (step && a_hit && !is_cap) || (pend_q && tick_q);
  assign set_p = step && p_hit && !is_sp && !(is_cmp && clr_src);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      if (set_a) begin
        flag_a_q <= 1'b1;
      end else if (bus_wr && wa_q == `PDT_OFF_FLAGS && hwdata[0]) begin
        flag_a_q <= 1'b0;
      end
      if (set_p) begin
        flag_p_q <= 1'b1;
      end else if (bus_wr && wa_q == `PDT_OFF_FLAGS && hwdata[1]) begin
        flag_p_q <= 1'b0;
      end
    end
  end

  // compare-mode pin level, moved only by A match or run rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 1'b0;
    end else if (run_rise) begin
      lvl_q <= init_lvl;
    end else if (mode == PDT_MODE_CMP && step && a_hit) begin
      case (pinfn)
        `PDT_PIN_LOW: lvl_q <= 1'b0;
        `PDT_PIN_HIGH: lvl_q <= 1'b1;
        `PDT_PIN_TOG: lvl_q <= !lvl_q;
        default: lvl_q <= lvl_q;
      endcase
    end
  end

  logic out_d, en_d;
  always_comb begin
    out_d = 1'b0;
    en_d = 1'b1;
    if (mode == PDT_MODE_CMP) begin
      out_d = lvl_q ^ inv;
    end else if (is_pwm) begin
      case (pinfn)
        `PDT_PIN_INACT: out_d = !init_lvl ^ inv;
        `PDT_PIN_ACT: out_d = init_lvl ^ inv;
        default: out_d = (run && duty_on ? init_lvl : !init_lvl) ^ inv;
      endcase
    end else if (is_sp) begin
      out_d = (run ? init_lvl : !init_lvl) ^ inv;
    end else begin
      en_d = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= 1'b0;
      out_en_q <= 1'b0;
    end else begin
      out_q <= out_d;
      out_en_q <= en_d;
    end
  end
  assign timer_out = out_q;
  assign timer_out_en = out_en_q;

  localparam int LAT_MAX = `PDT_TICK_DIV + 1;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_tc_idle;
    mode == PDT_MODE_TC |=> !timer_out_en;
  endproperty
  a_tc_idle: assert property (p_tc_idle) else $error("pin driven");
  property p_lvl_hold;
    !run_rise && !(step && a_hit) |=> $stable(lvl_q);
  endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("level moved");
  property p_init;
    run_rise |=> lvl_q == $past(init_lvl);
  endproperty
  a_init: assert property (p_init) else $error("no init level");
  property p_no_p;
    is_cmp && clr_src && !flag_p_q |=> !flag_p_q;
  endproperty
  a_no_p: assert property (p_no_p) else $error("p flag set");
  property p_pwm_clr;
    is_pwm && step && p_hit |=> cnt_q == `PDT_WORD_RST && flag_p_q;
  endproperty
  a_pwm_clr: assert property (p_pwm_clr) else $error("no clear");
  property p_full;
    is_pwm && pinfn == `PDT_PIN_PWM && run && duty_full
      |=> timer_out == $past(init_lvl ^ inv);
  endproperty
  a_full: assert property (p_full) else $error("not full duty");
  property p_trig;
    is_sp && ckp_rise && !(step && a_hit) |=> run;
  endproperty
  a_trig: assert property (p_trig) else $error("no trigger");
  property p_sp_end;
    is_sp && step && a_hit |=> !run && flag_a_q;
  endproperty
  a_sp_end: assert property (p_sp_end) else $error("pulse not ended");
  property p_sp_zero;
    is_sp && run_rise |=> cnt_q == `PDT_WORD_RST;
  endproperty
  a_sp_zero: assert property (p_sp_zero) else $error("no restart");
  property p_lat_a;
    latch && cclr_q == 2'h0 |=> compare_register_a_q == $past(cnt_q);
  endproperty
  a_lat_a: assert property (p_lat_a) else $error("not latched");
  property p_lat_flag;
    latch |-> ##[1:LAT_MAX] flag_a_q;
  endproperty
  a_lat_flag: assert property (p_lat_flag) else $error("late flag");
  c_pwm: cover property (is_pwm && step && p_hit);
  c_sp: cover property (is_sp && step && a_hit);
  c_cap: cover property (latch && clr_evt);
endmodule

// file: design/pdt_timer_consts.svh
// constant macros for the ten-bit periodic timer
// assumes: included by the timer top, the pin source and the bench, 32-bit bus words
`ifndef PDT_TIMER_CONSTS_SVH
`define PDT_TIMER_CONSTS_SVH
`define PDT_OFF_CTRL 8'h00
`define PDT_OFF_CTRL2 8'h04
`define PDT_OFF_FLAGS 8'h08
`define PDT_OFF_COUNT 8'h0C
`define PDT_OFF_COMPARE_REGISTER_A 8'h10
`define PDT_OFF_COMPARE_REGISTER_B 8'h14
`define PDT_OFF_PERIOD_REGISTER 8'h18
`define PDT_B_CLRSRC 4
`define PDT_B_RUN 5
`define PDT_B_INIT 6
`define PDT_B_INV 7
`define PDT_B_CAPSRC 8
`define PDT_CTRL_W 9
`define PDT_CTRL_RST 9'h000
`define PDT_WORD_RST 10'h000
`define PDT_WORD_ONE 10'h001
`define PDT_TICK_DIV 4
`define PDT_DIV_W 3
`define PDT_PIN_LOW 2'h1
`define PDT_PIN_HIGH 2'h2
`define PDT_PIN_TOG 2'h3
`define PDT_PIN_PWM 2'h2
`define PDT_PIN_ONCE 2'h3
`define PDT_EDGE_RISE 2'h0
`define PDT_EDGE_FALL 2'h1
`define PDT_EDGE_BOTH 2'h2
`define PDT_F_MODE 1:0
`define PDT_F_PINFN 3:2
`define PDT_F_CCLR 2:1
`define PDT_F_WORD 9:0
`define PDT_PIN_INACT 2'h0
`define PDT_PIN_ACT 2'h1
`define PDT_CLR_RISE 2'h1
`define PDT_CLR_FALL 2'h2
`define PDT_CLR_BOTH 2'h3
`endif

// file: design/pdt_timer_pkg.sv
// types shared by the periodic timer
// assumes: mode values here fit the two-bit mode field in the consts header
package pdt_timer_pkg;
  typedef logic [9:0] pdt_word_t;
  typedef enum logic [1:0] {
    PDT_MODE_CMP = 2'h0,
    PDT_MODE_CAP = 2'h1,
    PDT_MODE_PWM = 2'h2,
    PDT_MODE_TC = 2'h3
  } pdt_mode_t;
endpackage

// file: test/pdt_pin_src.sv
// pulse source model for the timer clock and capture input pins
// assumes: pins sampled on hclk rising edges, idle low
`timescale 1ns/1ps
`include "pdt_timer_consts.svh"
module pdt_pin_src (
  input wire logic hclk,
  output logic timer_clock_pin,
  output logic capture_input_pin
);
  initial begin
    timer_clock_pin = 1'b0;
    capture_input_pin = 1'b0;
  end
  // shorter pulses may be dropped by the timer, so never go below
  task automatic pulse(input logic sel, input int w);
    int n;
    n = (w < 2 * `PDT_TICK_DIV) ? 2 * `PDT_TICK_DIV : w;
    @(posedge hclk);
    if (sel) timer_clock_pin <= 1'b1;
    else capture_input_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    timer_clock_pin <= 1'b0;
    capture_input_pin <= 1'b0;
  endtask
endmodule

// file: test/pdt_timer_tb_top.sv
// self-checking bench for the periodic timer over AHB-Lite
// assumes: pin source model drives both timer input pins
`timescale 1ns/1ps
`include "pdt_timer_consts.svh"
module pdt_timer_tb_top;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timer_out, timer_out_en, timer_clock_pin, capture_input_pin;
  wire logic hready;
  int fails, n_tests, c;
  assign hready = hreadyout;
  pdt_timer u_pdt_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .timer_clock_pin(timer_clock_pin),
    .capture_input_pin(capture_input_pin),
    .timer_out(timer_out), .timer_out_en(timer_out_en));
  pdt_pin_src u_pdt_pin_src (.hclk(hclk),
    .timer_clock_pin(timer_clock_pin),
    .capture_input_pin(capture_input_pin));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task hwait();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (hready !== 1'b1) begin
      chk(1'b0, "bus timeout");
      final_report();
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
  endtask
  task rd(input logic [31:0] a, output logic [31:0] d);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwait();
    d = hrdata;
  endtask
  task rc(input logic [31:0] a, input logic [31:0] e, input string m);
    rd(a, v);
    chk(v === e, m);
  endtask
  task idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task high(input int n);
    c = 0;
    repeat (n) begin
      @(posedge hclk);
      if (timer_out === 1'b1) c++;
    end
  endtask
  // run rise in single pulse mode zeroes the count at once; count writes are ignored
  task zero();
    wr(`PDT_OFF_CTRL, 32'h0E);
    wr(`PDT_OFF_CTRL, 32'h2E);
    wr(`PDT_OFF_CTRL, 32'h0);
  endtask
  task t_regs();
    rc(`PDT_OFF_CTRL, 32'h0, "ctrl reset");
    rc(`PDT_OFF_COUNT, 32'h0, "count reset");
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'hFFFFFFFF);
    rc(`PDT_OFF_COMPARE_REGISTER_A, 32'h3FF, "ten bits");
    wr(`PDT_OFF_COUNT, 32'h55);
    rc(`PDT_OFF_COUNT, 32'h0, "count read only");
    wr(32'h1C, 32'h55);
    rc(32'h1C, 32'h0, "unmapped");
    chk(hresp === 1'b0, "okay");
    $display("test regs done");
  endtask
  task t_pwm();
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h4);
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h2);
    wr(`PDT_OFF_CTRL, 32'h6A);
    idle(20);
    high(64);
    chk(c == 32, "pwm duty");
    chk(timer_out_en === 1'b1, "pwm drive");
    rc(`PDT_OFF_FLAGS, 32'h3, "pwm flags");
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h5);
    idle(20);
    high(64);
    chk(c == 64, "full duty");
    wr(`PDT_OFF_CTRL, 32'hEA);
    idle(20);
    high(64);
    chk(c == 0, "inverted");
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h2);
    wr(`PDT_OFF_CTRL, 32'h66);
    idle(20);
    high(64);
    chk(c == 64, "forced active");
    wr(`PDT_OFF_CTRL, 32'h72);
    wr(`PDT_OFF_FLAGS, 32'h3);
    high(40);
    chk(c == 0, "forced inactive");
    rc(`PDT_OFF_FLAGS, 32'h3, "flags run on");
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h0);
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h200);
    wr(`PDT_OFF_CTRL, 32'h6A);
    idle(20);
    high(4096);
    chk(c == 2048, "period 1024");
    $display("test pwm done");
  endtask
  task t_cmp();
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h3);
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h1);
    zero();
    wr(`PDT_OFF_CTRL, 32'h7C);
    idle(3);
    chk(timer_out === 1'b1, "initial high");
    chk(timer_out_en === 1'b1, "compare drive");
    wr(`PDT_OFF_FLAGS, 32'h3);
    high(64);
    chk(c == 32, "compare toggle");
    rc(`PDT_OFF_FLAGS, 32'h1, "clear on a");
    wr(`PDT_OFF_CTRL, 32'h7F);
    wr(`PDT_OFF_FLAGS, 32'h3);
    idle(60);
    chk(timer_out_en === 1'b0, "tc pin free");
    rc(`PDT_OFF_FLAGS, 32'h1, "tc flags");
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h0);
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h2);
    zero();
    wr(`PDT_OFF_CTRL, 32'h2C);
    idle(3);
    chk(timer_out === 1'b0, "initial low");
    wr(`PDT_OFF_FLAGS, 32'h3);
    high(60);
    chk(c == 0, "p match pin");
    rc(`PDT_OFF_FLAGS, 32'h2, "p flag");
    $display("test compare done");
  endtask
  task t_pulse();
    wr(`PDT_OFF_CTRL, 32'h0);
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h0);
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h14);
    wr(`PDT_OFF_CTRL, 32'h4E);
    wr(`PDT_OFF_FLAGS, 32'h3);
    u_pdt_pin_src.pulse(1'b1, 8);
    chk(timer_out === 1'b1, "leading edge");
    rc(`PDT_OFF_CTRL, 32'h6E, "run set by pin");
    idle(100);
    chk(timer_out === 1'b0, "trailing edge");
    rc(`PDT_OFF_CTRL, 32'h4E, "run cleared");
    rc(`PDT_OFF_FLAGS, 32'h1, "pulse flag");
    wr(`PDT_OFF_CTRL, 32'h6E);
    idle(1);
    rd(`PDT_OFF_COUNT, v);
    chk(v < 3, "count zeroed");
    wr(`PDT_OFF_CTRL, 32'h4E);
    idle(2);
    chk(timer_out === 1'b0, "software stop");
    $display("test pulse done");
  endtask
  task t_cap();
    zero();
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h3);
    wr(`PDT_OFF_CTRL2, 32'h0);
    wr(`PDT_OFF_CTRL, 32'h21);
    wr(`PDT_OFF_FLAGS, 32'h3);
    idle(40);
    rd(`PDT_OFF_COUNT, v);
    chk(v < 3, "period wrap");
    rc(`PDT_OFF_FLAGS, 32'h2, "period flag");
    wr(`PDT_OFF_PERIOD_REGISTER, 32'h0);
    wr(`PDT_OFF_FLAGS, 32'h3);
    idle(40);
    u_pdt_pin_src.pulse(1'b0, 8);
    idle(6);
    rd(`PDT_OFF_COMPARE_REGISTER_A, v);
    chk(v != 0 && v < 32'h20, "capture to a");
    rc(`PDT_OFF_FLAGS, 32'h1, "capture flag");
    wr(`PDT_OFF_CTRL2, 32'h2);
    idle(20);
    u_pdt_pin_src.pulse(1'b0, 8);
    rd(`PDT_OFF_COUNT, v);
    chk(v < 4, "rise clears");
    rd(`PDT_OFF_COMPARE_REGISTER_B, v);
    chk(v != 0, "clearing edge to b");
    rc(`PDT_OFF_CTRL2, 32'h3, "rise edge flag");
    wr(`PDT_OFF_CTRL, 32'h25);
    wr(`PDT_OFF_CTRL2, 32'h4);
    idle(20);
    u_pdt_pin_src.pulse(1'b0, 8);
    idle(1);
    rd(`PDT_OFF_COUNT, v);
    chk(v < 2, "fall clears");
    idle(4);
    rc(`PDT_OFF_CTRL2, 32'h4, "fall edge flag");
    wr(`PDT_OFF_CTRL, 32'h29);
    wr(`PDT_OFF_CTRL2, 32'h6);
    u_pdt_pin_src.pulse(1'b0, 8);
    idle(6);
    rc(`PDT_OFF_CTRL2, 32'h6, "both edges");
    wr(`PDT_OFF_CTRL2, 32'h0);
    wr(`PDT_OFF_CTRL, 32'h2D);
    wr(`PDT_OFF_COMPARE_REGISTER_A, 32'h0);
    u_pdt_pin_src.pulse(1'b0, 8);
    idle(6);
    rc(`PDT_OFF_COMPARE_REGISTER_A, 32'h0, "no capture");
    rd(`PDT_OFF_COUNT, v);
    chk(v != 0, "count runs");
    wr(`PDT_OFF_CTRL, 32'h121);
    u_pdt_pin_src.pulse(1'b1, 8);
    idle(6);
    rd(`PDT_OFF_COMPARE_REGISTER_A, v);
    chk(v != 0, "clock pin source");
    $display("test capture done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fails = 0;
    n_tests = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_pwm();
    t_cmp();
    t_pulse();
    t_cap();
    final_report();
  end
endmodule
